// File: pkg/hss_regs.vh
// Constants for the high-side switch fault controller: register map,
// field positions, reset values, variant codes and timing counts.
// Included by bare name; definitions only.
`ifndef HSS_REGS_VH
`define HSS_REGS_VH

// Timebase
`define HSS_CLK_PERIOD_NS 10
// Overcurrent deglitch time and its cycle count
`define HSS_DEGLITCH_NS 3000
`define HSS_DEGLITCH_CYCLES ((`HSS_DEGLITCH_NS) / (`HSS_CLK_PERIOD_NS))
`define HSS_DEGLITCH_W 9
// Retry interval and its cycle count
`define HSS_RETRY_US 1000
`define HSS_RETRY_CYCLES (((`HSS_RETRY_US) * 1000) / (`HSS_CLK_PERIOD_NS))
`define HSS_RETRY_W 17
// Consecutive fault shutdowns before the limit is halved
`define HSS_FOLD_COUNT 3'h7

// Product variant codes
`define HSS_VAR_SHUTOFF 2'h0
`define HSS_VAR_FOLDBACK 2'h1
`define HSS_VAR_ACTIVE 2'h2

// Register byte offsets
`define HSS_REG_CTRL 4'h0
`define HSS_REG_STATUS 4'h4
`define HSS_REG_EVENT 4'h8
`define HSS_ADDR_W 4

// Control register fields and reset value
`define HSS_CTRL_ENGATE 0
`define HSS_CTRL_RESET 32'h00000001

// Status register field positions
`define HSS_ST_STATE 0
`define HSS_ST_ABS 2
`define HSS_ST_REL 3
`define HSS_ST_CL 4
`define HSS_ST_UVLO 5
`define HSS_ST_RETRYIND 6
`define HSS_ST_COUNT 7
`define HSS_ST_HALF 10
`define HSS_ST_DEFLIM 11
`define HSS_ST_SWITCH 12
`define HSS_ST_SENSE 13

// Event register fields (sticky, write one to clear)
`define HSS_EV_ABS 0
`define HSS_EV_REL 1
`define HSS_EV_CL 2
`define HSS_EV_UVLO 3
`define HSS_EV_W 4

// AXI responses
`define HSS_RESP_OKAY 2'h0
`define HSS_RESP_SLVERR 2'h2

`endif

// File: design/hss_sync.v
// Two-flop synchroniser for a bundle of asynchronous level inputs.
// Assumes each bit is an independent level; no bus coherency.
`timescale 1ns/1ns
module hss_sync #(
  parameter WIDTH = 10
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);
  genvar i;
  // One stage pair per bit; first stage feeds only the second
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_q;
      reg sync_q;
      always @(posedge clk) begin
        if (rst) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else if (ce) begin
          meta_q <= din[i];
          sync_q <= meta_q;
        end
      end
      assign dout[i] = sync_q;
    end
  endgenerate
endmodule // hss_sync

// File: design/hss_deglitch.v
// Persistence filter: output rises once the input has stayed high for
// CYCLES consecutive enabled clocks, falls with the input.
// Assumes the input is already synchronous to clk.
`timescale 1ns/1ns
module hss_deglitch #(
  parameter CYCLES = 300,
  parameter W = 9
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire din,
  output reg dout
);
  localparam integer LAST_FULL = CYCLES - 1;
  localparam [W-1:0] LAST = LAST_FULL[W-1:0];
  reg [W-1:0] cnt_q;

  // Any low sample restarts the count, so short spikes never pass
  always @(posedge clk) begin
    if (rst) begin
      cnt_q <= {W{1'b0}};
      dout <= 1'b0;
    end else if (ce) begin
      if (!din) begin
        cnt_q <= {W{1'b0}};
        dout <= 1'b0;
      end else if (cnt_q == LAST) begin
        dout <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule // hss_deglitch

// File: design/hss_fault_ctrl.v
// Fault-protection controller of a single-channel high-side switch,
// with an AXI4-Lite slave for control, status and sticky events.
// Assumes analog comparators and pins arrive asynchronously; variant is static.
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`include "hss_regs.vh"
`timescale 1ns/1ns
module hss_fault_ctrl #(
  parameter RETRY_CYCLES = `HSS_RETRY_CYCLES,
  parameter RETRY_W = `HSS_RETRY_W,
  parameter DEGLITCH_CYCLES = `HSS_DEGLITCH_CYCLES
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire [1:0] variant,
  input wire enablePin,
  input wire latchPin,
  input wire tempAbsHot,
  input wire tempAbsCool,
  input wire tempRelHot,
  input wire overCurrent,
  input wire supplyLowFall,
  input wire supplyHighRise,
  input wire outNearSupply,
  input wire limitResOk,
  output reg switchOn,
  output reg senseFault,
  output reg limitHalf,
  output reg limitDefault,
  output reg limitRegulate,
  input wire [`HSS_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`HSS_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam [1:0] ST_OFF = 2'h0;
  localparam [1:0] ST_ON = 2'h1;
  localparam [1:0] ST_FAULT = 2'h2;
  localparam [RETRY_W-1:0] RETRY_LOAD = RETRY_CYCLES[RETRY_W-1:0];
  localparam [31:0] CTRL_RST = `HSS_CTRL_RESET;

  wire [9:0] syncOut;
  wire enS, latchS, absHotS, absCoolS, relHotS, ocS;
  wire lowFallS, highRiseS, nearS, resOkS, ocDeg;
  reg [1:0] state_q, state_d;
  reg absFault_q, relFault_q, clFault_q, uvlo_q, retryInd_q, ctrlEnGate_q, rdHit;
  reg [RETRY_W-1:0] retryCnt_q;
  reg [2:0] foldCnt_q;
  reg [`HSS_EV_W-1:0] event_q;
  reg awHave_q, wHave_q;
  reg [`HSS_ADDR_W-1:0] awAddr_q;
  reg [31:0] wData_q;
  reg [3:0] wStrb_q;
  reg [31:0] rdMux;

  // Every comparator and pin crosses two flops before use
  hss_sync #(
    .WIDTH(10)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .din({limitResOk, outNearSupply, supplyHighRise, supplyLowFall, overCurrent,
      tempRelHot, tempAbsCool, tempAbsHot, latchPin, enablePin}),
    .dout(syncOut)
  );
  assign {resOkS, nearS, highRiseS, lowFallS, ocS, relHotS, absCoolS, absHotS,
    latchS, enS} = syncOut;

  // Short-circuit event only after persistent overcurrent
  hss_deglitch #(
    .CYCLES(DEGLITCH_CYCLES),
    .W(`HSS_DEGLITCH_W)
  ) u_deglitch (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .din(ocS),
    .dout(ocDeg)
  );

  // Variant decode; the variant is a static strap
  wire shutoffVar = (variant != `HSS_VAR_ACTIVE);
  wire foldVar = (variant == `HSS_VAR_FOLDBACK);
  wire enEff = enS & ctrlEnGate_q;
  // Active variant ignores current trips and waits for heat
  wire clTrip = shutoffVar & ocDeg;
  wire thermTrip = absHotS | relHotS;
  wire faultTrip = (state_q == ST_ON) & (thermTrip | clTrip);
  wire retryDone = (retryCnt_q == {RETRY_W{1'b0}});
  wire faultsClear = !absFault_q & !relFault_q & !clFault_q;
  wire releaseOk = (state_q == ST_FAULT) & !latchS & retryDone & faultsClear;
  wire retrySet = releaseOk & (state_d == ST_ON);
  wire regulating = !shutoffVar & (state_q == ST_ON) & ocS;

  // Fault state machine
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_OFF: begin
        if (enEff && !uvlo_q) begin
          state_d = ST_ON;
        end
      end
      ST_ON: begin
        if (thermTrip || clTrip) begin
          state_d = ST_FAULT;
        end else if (!enEff || uvlo_q) begin
          state_d = ST_OFF;
        end
      end
      ST_FAULT: begin
        if (releaseOk) begin
          state_d = (enEff && !uvlo_q) ? ST_ON : ST_OFF;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
  end

  // State, retry timer and undervoltage latch
  always @(posedge clk) begin
    if (rst) begin
      state_q <= ST_OFF;
      retryCnt_q <= {RETRY_W{1'b0}};
      uvlo_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      // Timer armed on each fault shutdown, runs down while held off
      if (faultTrip) begin
        retryCnt_q <= RETRY_LOAD;
      end else if (state_q == ST_FAULT && !retryDone) begin
        retryCnt_q <= retryCnt_q - 1'b1;
      end
      // Set wins, so a dip during recovery is never missed
      if (lowFallS) begin
        uvlo_q <= 1'b1;
      end else if (highRiseS) begin
        uvlo_q <= 1'b0;
      end
    end
  end

  // Individual fault flags; a new trip outranks its own clear
  always @(posedge clk) begin
    if (rst) begin
      absFault_q <= 1'b0;
      relFault_q <= 1'b0;
      clFault_q <= 1'b0;
    end else if (ce) begin
      if (faultTrip && absHotS) begin
        absFault_q <= 1'b1;
      end else if (absCoolS) begin
        absFault_q <= 1'b0;
      end
      if (faultTrip && relHotS) begin
        relFault_q <= 1'b1;
      end else if (state_q == ST_FAULT && retryDone) begin
        relFault_q <= 1'b0;
      end
      if (faultTrip && clTrip) begin
        clFault_q <= 1'b1;
      end else if (!ocS) begin
        clFault_q <= 1'b0;
      end
    end
  end

  // Foldback counter; only the foldback variant ever counts
  always @(posedge clk) begin
    if (rst) begin
      foldCnt_q <= 3'h0;
    end else if (ce) begin
      if (!foldVar) begin
        foldCnt_q <= 3'h0;
      end else if (faultTrip) begin
        if (foldCnt_q != `HSS_FOLD_COUNT) begin
          foldCnt_q <= foldCnt_q + 3'h1;
        end
      end else if (state_q == ST_ON && state_d == ST_OFF) begin
        foldCnt_q <= 3'h0;
      end else if (state_q == ST_OFF && !enEff) begin
        foldCnt_q <= 3'h0;
      end
    end
  end

  // Retry indication holds until the output climbs near supply or the switch goes off
  always @(posedge clk) begin
    if (rst) begin
      retryInd_q <= 1'b0;
    end else if (ce) begin
      if (retrySet) begin
        retryInd_q <= 1'b1;
      end else if (nearS || state_q == ST_OFF) begin
        retryInd_q <= 1'b0;
      end
    end
  end

  // Registered outputs toward the power stage and sense mux
  always @(posedge clk) begin
    if (rst) begin
      switchOn <= 1'b0;
      senseFault <= 1'b0;
      limitHalf <= 1'b0;
      limitDefault <= 1'b0;
      limitRegulate <= 1'b0;
    end else if (ce) begin
      // Raw overcurrent cuts the gate before the deglitch ends, except in the active variant
      switchOn <= (state_d == ST_ON) & !uvlo_q & !(shutoffVar & ocS);
      senseFault <= (state_d == ST_FAULT) | regulating | retryInd_q | retrySet;
      limitHalf <= foldVar & (foldCnt_q == `HSS_FOLD_COUNT);
      limitDefault <= !resOkS;
      limitRegulate <= regulating;
    end
  end

  // Sticky event bits; set beats a same-cycle write-one clear
  wire [`HSS_EV_W-1:0] evSet;
  assign evSet[`HSS_EV_ABS] = faultTrip & absHotS;
  assign evSet[`HSS_EV_REL] = faultTrip & relHotS;
  assign evSet[`HSS_EV_CL] = faultTrip & clTrip;
  assign evSet[`HSS_EV_UVLO] = lowFallS & !uvlo_q;
  wire doWrite = awHave_q & wHave_q & !s_axi_bvalid;
  wire wrCtrl = doWrite & (awAddr_q == `HSS_REG_CTRL) & wStrb_q[0];
  wire wrEvent = doWrite & (awAddr_q == `HSS_REG_EVENT) & wStrb_q[0];
  wire wrHit = (awAddr_q == `HSS_REG_CTRL) | (awAddr_q == `HSS_REG_EVENT);

  always @(posedge clk) begin
    if (rst) begin
      ctrlEnGate_q <= CTRL_RST[`HSS_CTRL_ENGATE];
      event_q <= {`HSS_EV_W{1'b0}};
    end else if (ce) begin
      if (wrCtrl) begin
        ctrlEnGate_q <= wData_q[`HSS_CTRL_ENGATE];
      end
      if (wrEvent) begin
        event_q <= (event_q & ~wData_q[`HSS_EV_W-1:0]) | evSet;
      end else begin
        event_q <= event_q | evSet;
      end
    end
  end

  // Read decode; unmapped words read zero with an error response
  always @* begin
    rdMux = 32'h00000000;
    rdHit = 1'b1;
    case ({s_axi_araddr[`HSS_ADDR_W-1:2], 2'h0})
      `HSS_REG_CTRL: begin
        rdMux[`HSS_CTRL_ENGATE] = ctrlEnGate_q;
      end
      `HSS_REG_STATUS: begin
        rdMux[`HSS_ST_STATE+1:`HSS_ST_STATE] = state_q;
        rdMux[`HSS_ST_ABS] = absFault_q;
        rdMux[`HSS_ST_REL] = relFault_q;
        rdMux[`HSS_ST_CL] = clFault_q;
        rdMux[`HSS_ST_UVLO] = uvlo_q;
        rdMux[`HSS_ST_RETRYIND] = retryInd_q;
        rdMux[`HSS_ST_COUNT+2:`HSS_ST_COUNT] = foldCnt_q;
        rdMux[`HSS_ST_HALF] = limitHalf;
        rdMux[`HSS_ST_DEFLIM] = limitDefault;
        rdMux[`HSS_ST_SWITCH] = switchOn;
        rdMux[`HSS_ST_SENSE] = senseFault;
      end
      `HSS_REG_EVENT: begin
        rdMux[`HSS_EV_W-1:0] = event_q;
      end
      default: begin
        rdHit = 1'b0;
      end
    endcase
  end

  // Write channels: address and data taken in either order
  always @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `HSS_RESP_OKAY;
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= {`HSS_ADDR_W{1'b0}};
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awHave_q <= 1'b1;
        awAddr_q <= {s_axi_awaddr[`HSS_ADDR_W-1:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wHave_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? `HSS_RESP_OKAY : `HSS_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        // Ready returns only after the response, one write in flight
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read channel: data captured at the address handshake
  always @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `HSS_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdHit ? `HSS_RESP_OKAY : `HSS_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // hss_fault_ctrl

// File: test/hss_fault_ctrl_sva.sv
// Assertion checker for the switch fault controller, bound to its top module.
// Assumes the clock enable stays high while checking; reset is synchronous.
`timescale 1ns/1ns
module hss_fault_ctrl_sva #(
  parameter DEGLITCH_CYCLES = 300
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire [1:0] variant,
  input wire enablePin,
  input wire latchPin,
  input wire tempAbsHot,
  input wire tempAbsCool,
  input wire tempRelHot,
  input wire overCurrent,
  input wire supplyLowFall,
  input wire limitResOk,
  input wire switchOn,
  input wire senseFault,
  input wire limitHalf,
  input wire limitDefault,
  input wire limitRegulate
);
  reg [11:0] runLen_q;
  reg [11:0] peakLen_q;
  reg [3:0] quiet_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Longest recent overcurrent run; forgotten after eight quiet cycles so that
  // the fault may land a few cycles after the raw input falls
  always @(posedge clk) begin
    if (rst) begin
      runLen_q <= 12'h0;
      peakLen_q <= 12'h0;
      quiet_q <= 4'h0;
    end else if (ce) begin
      runLen_q <= overCurrent ? runLen_q + 12'h1 : 12'h0;
      quiet_q <= overCurrent ? 4'h0 : (quiet_q == 4'h8 ? quiet_q : quiet_q + 4'h1);
      peakLen_q <= (quiet_q == 4'h8) ? 12'h0 : (runLen_q > peakLen_q ? runLen_q : peakLen_q);
    end
  end
  AST_ABS_OFF: assert property (
    (tempAbsHot && !tempAbsCool && ce) [*4] |=> !switchOn) else $error("on through heat trip");
  AST_SENSE: assert property (
    (tempAbsHot && !tempAbsCool && ce) [*3] ##0 $fell(switchOn) |-> senseFault)
    else $error("fault shutdown without sense flag");
  AST_DEGLITCH: assert property (
    $rose(senseFault) && variant != 2'h2 && !tempAbsHot && !tempRelHot
    |-> peakLen_q >= DEGLITCH_CYCLES - 1 || runLen_q >= DEGLITCH_CYCLES - 1)
    else $error("current fault before deglitch time");
  AST_OC_OFF: assert property (
    (overCurrent && ce && variant != 2'h2) [*4] |=> !switchOn) else $error("on over limit");
  AST_LATCH: assert property (
    (latchPin && !overCurrent && ce) [*4] ##0 (senseFault && !switchOn) |=> !switchOn)
    else $error("latched fault released");
  AST_UVLO: assert property (
    (supplyLowFall && ce) [*5] |=> !switchOn) else $error("on at low supply");
  AST_REGULATE: assert property (
    (variant == 2'h2 && overCurrent && switchOn && ce) [*4] |-> senseFault && limitRegulate)
    else $error("regulation not flagged");
  AST_ACTIVE_ON: assert property (
    (variant == 2'h2 && enablePin && !latchPin && !tempAbsHot && !tempRelHot
    && !supplyLowFall && ce) [*4] ##0 switchOn |=> switchOn) else $error("active variant cut");
  AST_CONST_LIMIT: assert property (
    variant != 2'h1 |-> !limitHalf) else $error("limit halved outside foldback");
  AST_DEFAULT: assert property (
    (ce && !rst && $stable(limitResOk)) [*4] |-> limitDefault == !limitResOk)
    else $error("default limit select wrong");
endmodule // hss_fault_ctrl_sva

bind hss_fault_ctrl hss_fault_ctrl_sva #(.DEGLITCH_CYCLES(DEGLITCH_CYCLES)) chk (
  .clk, .rst, .ce, .variant, .enablePin, .latchPin, .tempAbsHot, .tempAbsCool, .tempRelHot,
  .overCurrent, .supplyLowFall, .limitResOk, .switchOn, .senseFault, .limitHalf,
  .limitDefault, .limitRegulate);

// File: test/hss_mcu_model.sv
// Host controller model driving the enable and latch pins of the switch.
// Assumes bench commands that change just after a clock edge.
`timescale 1ns/1ns
module hss_mcu_model (
  input wire clk,
  input wire rst,
  input wire wantOn,
  input wire wantLatch,
  input wire supplyOk,
  output reg enablePin,
  output reg latchPin
);
  reg upSeen_q;
  // Enable held low until the supply has first come up, so a slow ramp
  // never sees a request near the lockout edge
  always @(posedge clk) begin
    if (rst) begin
      upSeen_q <= 1'b0;
      enablePin <= 1'b0;
      latchPin <= 1'b0;
    end else begin
      upSeen_q <= upSeen_q | supplyOk;
      enablePin <= wantOn & (upSeen_q | supplyOk);
      latchPin <= wantLatch;
    end
  end
endmodule // hss_mcu_model

// File: test/tb_top.sv
// Self-checking bench for the switch fault controller and its register bus.
// Assumes the constants header and the host pin model are compiled first.
`include "hss_regs.vh"
`timescale 1ns/1ns
module tb_top;
  localparam int RETRY = 20;
  localparam int DEGL = 5;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, wantOn = 1'b0, wantLatch = 1'b0, supplyOk = 1'b1;
  logic tempAbsHot = 1'b0, tempAbsCool = 1'b1, tempRelHot = 1'b0, overCurrent = 1'b0;
  logic supplyLowFall = 1'b0, supplyHighRise = 1'b1, outNearSupply = 1'b0, limitResOk = 1'b1;
  logic [1:0] variant = 2'h0;
  logic enablePin, latchPin, switchOn, senseFault, limitHalf, limitDefault, limitRegulate;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int badCount = 0, comparisons = 0, cycles = 0, foldCnt = 0;
  // Free-running 100 MHz clock
  always #5 clk = ~clk;
  hss_mcu_model mcu (.clk, .rst, .wantOn, .wantLatch, .supplyOk, .enablePin, .latchPin);
  hss_fault_ctrl #(.RETRY_CYCLES(RETRY), .DEGLITCH_CYCLES(DEGL)) dut (
    .clk, .rst, .ce, .variant, .enablePin, .latchPin, .tempAbsHot, .tempAbsCool, .tempRelHot,
    .overCurrent, .supplyLowFall, .supplyHighRise, .outNearSupply, .limitResOk, .switchOn,
    .senseFault, .limitHalf, .limitDefault, .limitRegulate, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      badCount++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Bounded wait for switchOn (sel 0) or senseFault (sel 1) to reach a level
  task automatic wt(input int sel, input logic v, input int lim);
    logic s;
    s = ~v;
    for (int n = 0; n < lim && s !== v; n++) begin
      @(posedge clk);
      s = sel ? senseFault : switchOn;
    end
    chk(sel ? "senseFault" : "switchOn", 32'(v), 32'(s));
  endtask
  // Bus write: both channels offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 40);
    s_axi_bready <= 1'b0;
    chk("bvalid", 32'h1, 32'(s_axi_bvalid));
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask
  // Bus read; data taken at the edge that sees rvalid
  task automatic rdr(input logic [3:0] a, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 40);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    chk("rvalid", 32'h1, 32'(s_axi_rvalid));
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard, well above the several hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      badCount++;
      results();
    end
  end
  initial begin
    rd = $urandom(32'hed13);
    tk(2);
    rst <= 1'b0;
    tk(1);
    rdr(`HSS_REG_CTRL, `HSS_RESP_OKAY);
    chk("ctrl", `HSS_CTRL_RESET, rd);
    rdr(4'hc, `HSS_RESP_SLVERR);
    chk("unmapped", 32'h0, rd);
    wr(`HSS_REG_STATUS, 32'h0, `HSS_RESP_SLVERR);
    wr(`HSS_REG_CTRL, $urandom | 32'h1, `HSS_RESP_OKAY);
    rdr(`HSS_REG_CTRL, `HSS_RESP_OKAY);
    chk("ctrl", 32'h1, rd);
    wantOn <= 1'b1;
    wt(0, 1'b1, 20);
    $display("test registers done");
    tempAbsHot <= 1'b1;
    tempAbsCool <= 1'b0;
    wt(0, 1'b0, 8);
    chk("senseFault", 32'h1, 32'(senseFault));
    rdr(`HSS_REG_STATUS, `HSS_RESP_OKAY);
    chk("abs flag", 32'h1, 32'(rd[`HSS_ST_ABS]));
    tk(2 * RETRY);
    tempAbsHot <= 1'b0;
    tk(RETRY);
    chk("switchOn", 32'h0, 32'(switchOn));
    tempAbsCool <= 1'b1;
    wt(0, 1'b1, 10);
    tk(3);
    chk("senseFault", 32'h1, 32'(senseFault));
    outNearSupply <= 1'b1;
    wt(1, 1'b0, 8);
    rdr(`HSS_REG_EVENT, `HSS_RESP_OKAY);
    chk("abs event", 32'h1, rd);
    wr(`HSS_REG_EVENT, 32'h1, `HSS_RESP_OKAY);
    rdr(`HSS_REG_EVENT, `HSS_RESP_OKAY);
    chk("event", 32'h0, rd);
    $display("test thermal done");
    wantLatch <= 1'b1;
    tempRelHot <= 1'b1;
    wt(0, 1'b0, 8);
    tempRelHot <= 1'b0;
    tk(3 * RETRY);
    chk("switchOn", 32'h0, 32'(switchOn));
    wantLatch <= 1'b0;
    wt(0, 1'b1, 10);
    overCurrent <= 1'b1;
    tk(1 + $urandom % 3);
    overCurrent <= 1'b0;
    tk(4);
    wt(0, 1'b1, 10);
    rdr(`HSS_REG_EVENT, `HSS_RESP_OKAY);
    chk("glitch event", 32'h0, 32'(rd[`HSS_EV_CL]));
    $display("test latch done");
    for (int i = 0; i < 9; i++) begin
      if (i == 1) begin
        wantOn <= 1'b0;
        wt(0, 1'b0, 10);
        variant <= 2'h1;
        wantOn <= 1'b1;
        wt(0, 1'b1, 10);
      end
      overCurrent <= 1'b1;
      wt(0, 1'b0, 6);
      tk(DEGL + 4);
      chk("senseFault", 32'h1, 32'(senseFault));
      overCurrent <= 1'b0;
      wt(0, 1'b1, RETRY + 10);
      foldCnt = (i == 0) ? 0 : (foldCnt < 7 ? foldCnt + 1 : 7);
      chk("limitHalf", 32'(foldCnt == 7), 32'(limitHalf));
    end
    rdr(`HSS_REG_STATUS, `HSS_RESP_OKAY);
    chk("count", 32'(foldCnt), 32'(rd[9:7]));
    wantOn <= 1'b0;
    wt(0, 1'b0, 10);
    tk(3);
    chk("limitHalf", 32'h0, 32'(limitHalf));
    $display("test foldback done");
    variant <= 2'h2;
    wantOn <= 1'b1;
    wt(0, 1'b1, 10);
    overCurrent <= 1'b1;
    tk(RETRY);
    chk("switchOn", 32'h1, 32'(switchOn));
    chk("regulate", 32'h1, 32'(limitRegulate & senseFault));
    tempRelHot <= 1'b1;
    wt(0, 1'b0, 8);
    overCurrent <= 1'b0;
    tempRelHot <= 1'b0;
    wt(0, 1'b1, RETRY + 10);
    supplyHighRise <= 1'b0;
    supplyLowFall <= 1'b1;
    wt(0, 1'b0, 8);
    chk("senseFault", 32'h0, 32'(senseFault));
    supplyLowFall <= 1'b0;
    tk(6);
    chk("switchOn", 32'h0, 32'(switchOn));
    supplyHighRise <= 1'b1;
    wt(0, 1'b1, 10);
    rdr(`HSS_REG_EVENT, `HSS_RESP_OKAY);
    chk("events", 32'((1 << `HSS_EV_REL) | (1 << `HSS_EV_CL) | (1 << `HSS_EV_UVLO)), rd);
    limitResOk <= 1'b0;
    tk(5);
    chk("limitDefault", 32'h1, 32'(limitDefault));
    $display("test active done");
    results();
  end
endmodule // tb_top
